/* common/sts_pkg.sv */
package sts_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int SLOT_W = 7;
   localparam int CNT_W = 16;
   localparam logic [ADDR_W-1:0] OFF_DATA_A = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_DATA_B = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RX_A = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_RX_B = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_TX_A = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_TX_B = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1c;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h20;
   localparam int IFACE_SEL_BIT = 7;
   localparam int CTRL_B_EN_BIT = 7;
   localparam int CTRL_A_EN_BIT = 6;
   localparam int CTRL_B_TYPE_LSB = 3;
   localparam int CTRL_A_TYPE_LSB = 0;
   localparam int STAT_WIN_BIT = 1;
   localparam int STAT_OVF_BIT = 0;
   localparam logic [BYTE_W-1:0] REG_RST = 8'h00;
   localparam int FRAME_US = 125;
   localparam int CLK_MHZ = 100;
   localparam int FRAME_CYC = FRAME_US * CLK_MHZ;
   localparam logic [CNT_W-1:0] CLOSE_BASE = 16'h0001;
   localparam logic [CNT_W-1:0] CLOSE_PER_CH = 16'h0010;
   localparam logic [2:0] CT_ILLEGAL = 3'h0;
   localparam logic [2:0] CT_FULL = 3'h1;
   localparam logic [2:0] CT_NIB_LO = 3'h2;
   localparam logic [2:0] CT_NIB_HI = 3'h3;
   localparam logic [2:0] CT_PAIR_0 = 3'h4;
   localparam logic [2:0] CT_PAIR_1 = 3'h5;
   localparam logic [2:0] CT_PAIR_2 = 3'h6;
   localparam logic [2:0] CT_PAIR_3 = 3'h7;

   typedef enum logic [2:0] {ST_OPEN, ST_WAIT, ST_WR, ST_RD, ST_RWAIT, ST_CAP} sts_phase_e;

   // Bits of a timeslot moved for a channel type
   function automatic logic [BYTE_W-1:0] type_mask(input logic [2:0] ct);
      logic [BYTE_W-1:0] m;
      m = 8'h00;
      case (ct)
         CT_FULL: m = 8'hff;
         CT_NIB_LO: m = 8'h0f;
         CT_NIB_HI: m = 8'hf0;
         CT_PAIR_0: m = 8'h03;
         CT_PAIR_1: m = 8'h0c;
         CT_PAIR_2: m = 8'h30;
         CT_PAIR_3: m = 8'hc0;
         default: m = 8'h00;
      endcase
      return m;
   endfunction
endpackage

/* core/sts_merge.sv */
`timescale 1ns/1ps
`default_nettype none
module sts_merge (
   input wire logic [2:0] ctype,
   input wire logic [sts_pkg::BYTE_W-1:0] old_byte,
   input wire logic [sts_pkg::BYTE_W-1:0] new_byte,
   output logic [sts_pkg::BYTE_W-1:0] merged,
   output logic [sts_pkg::BYTE_W-1:0] sel_mask
);
   import sts_pkg::*;
   // Only the selected sub-timeslot bits are replaced
   always_comb begin
      sel_mask = type_mask(ctype);
      merged = (old_byte & ~sel_mask) | (new_byte & sel_mask);
   end
endmodule
`default_nettype wire

/* core/sts_xfer.sv */
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sts_xfer #(
   parameter int unsigned FRAME_CYCLES = sts_pkg::FRAME_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sts_pkg::ADDR_W-1:0] paddr,
   input wire logic [sts_pkg::DATA_W-1:0] pwdata,
   output logic [sts_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mem_rd_en,
   output logic mem_rd_cfi,
   output logic [sts_pkg::SLOT_W-1:0] mem_rd_addr,
   input wire logic [sts_pkg::BYTE_W-1:0] mem_rd_data,
   output logic mem_wr_en,
   output logic mem_wr_cfi,
   output logic [sts_pkg::SLOT_W-1:0] mem_wr_addr,
   output logic [sts_pkg::BYTE_W-1:0] mem_wr_data,
   output logic [sts_pkg::BYTE_W-1:0] mem_wr_mask,
   output logic window_open,
   output logic irq
);
   import sts_pkg::*;

   localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_CYCLES - 1);

   typedef struct packed {
      sts_phase_e st;
      logic ch;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] open_len;
      logic full;
      logic [1:0][BYTE_W-1:0] data;
      logic [1:0][BYTE_W-1:0] rxa;
      logic [1:0][BYTE_W-1:0] txa;
      logic [BYTE_W-1:0] ctrl;
      logic [BYTE_W-1:0] mask;
      logic win_irq;
      logic ovf_irq;
      logic [1:0] acc;
      logic [DATA_W-1:0] prdata;
      logic rd_en;
      logic rd_cfi;
      logic [SLOT_W-1:0] rd_addr;
      logic wr_en;
      logic wr_cfi;
      logic [SLOT_W-1:0] wr_addr;
      logic [BYTE_W-1:0] wr_data;
      logic [BYTE_W-1:0] wr_mask;
   } sts_regs_s;

   sts_regs_s r_ff;
   sts_regs_s nxt_r;

   logic [1:0] en;
   logic [1:0][2:0] ctype;
   logic [1:0][BYTE_W-1:0] merged;
   logic [1:0][BYTE_W-1:0] sel_mask;
   logic [CNT_W-1:0] closed_len;
   logic [CNT_W-1:0] close_pos;
   logic any_en;
   logic acc_w;
   logic acc_r;
   logic setup_r;
   logic hit;
   logic rd_stat;
   logic close_ev;
   logic reopen;
   logic [BYTE_W-1:0] stat_byte;
   logic [BYTE_W-1:0] rd_byte;

   // Control field split: enables at bits 7 and 6, types at 5..3 and 2..0
   assign en[0] = r_ff.ctrl[CTRL_A_EN_BIT];
   assign en[1] = r_ff.ctrl[CTRL_B_EN_BIT];
   assign ctype[0] = r_ff.ctrl[CTRL_A_TYPE_LSB +: 3];
   assign ctype[1] = r_ff.ctrl[CTRL_B_TYPE_LSB +: 3];
   assign any_en = |en;

   // Closed time is 16 cycles per active channel plus one
   assign closed_len = CLOSE_BASE + ((en[0] && en[1]) ? 16'(CLOSE_PER_CH << 1) : CLOSE_PER_CH);
   assign close_pos = FRAME_LAST - closed_len;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_chan
         sts_merge u_merge (
            .ctype(ctype[gi]),
            .old_byte(r_ff.data[gi]),
            .new_byte(mem_rd_data),
            .merged(merged[gi]),
            .sel_mask(sel_mask[gi])
         );
      end
   endgenerate

   assign acc_w = psel && penable && pwrite;
   assign acc_r = psel && penable && !pwrite;
   assign setup_r = psel && !penable && !pwrite;
   assign rd_stat = acc_r && (paddr == OFF_STATUS);
   assign close_ev = window_open && (r_ff.cnt == close_pos);
   assign reopen = (r_ff.cnt == FRAME_LAST) && ((r_ff.st == ST_WAIT) || (r_ff.st == ST_OPEN));
   // Window only counts once it was armed at a frame wrap with a channel on
   assign window_open = (r_ff.st == ST_OPEN) && r_ff.full && any_en;

   always_comb begin
      stat_byte = 8'h00;
      stat_byte[STAT_WIN_BIT] = r_ff.win_irq;
      stat_byte[STAT_OVF_BIT] = r_ff.ovf_irq;
      hit = 1'b1;
      rd_byte = 8'h00;
      case (paddr)
         OFF_DATA_A: rd_byte = r_ff.data[0];
         OFF_DATA_B: rd_byte = r_ff.data[1];
         OFF_RX_A: rd_byte = r_ff.rxa[0];
         OFF_RX_B: rd_byte = r_ff.rxa[1];
         OFF_TX_A: rd_byte = r_ff.txa[0];
         OFF_TX_B: rd_byte = r_ff.txa[1];
         OFF_CTRL: rd_byte = r_ff.ctrl;
         OFF_STATUS: rd_byte = stat_byte;
         OFF_MASK: rd_byte = r_ff.mask;
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      nxt_r = r_ff;
      nxt_r.rd_en = 1'b0;
      nxt_r.wr_en = 1'b0;
      nxt_r.cnt = (r_ff.cnt == FRAME_LAST) ? '0 : r_ff.cnt + 16'h0001;
      if (setup_r) begin
         nxt_r.prdata = {24'h000000, rd_byte};
      end
      if (acc_w) begin
         case (paddr)
            OFF_DATA_A: if (window_open) nxt_r.data[0] = pwdata[BYTE_W-1:0];
            OFF_DATA_B: if (window_open) nxt_r.data[1] = pwdata[BYTE_W-1:0];
            OFF_RX_A: nxt_r.rxa[0] = pwdata[BYTE_W-1:0];
            OFF_RX_B: nxt_r.rxa[1] = pwdata[BYTE_W-1:0];
            OFF_TX_A: nxt_r.txa[0] = pwdata[BYTE_W-1:0];
            OFF_TX_B: nxt_r.txa[1] = pwdata[BYTE_W-1:0];
            OFF_CTRL: nxt_r.ctrl = pwdata[BYTE_W-1:0];
            OFF_MASK: nxt_r.mask = pwdata[BYTE_W-1:0];
            default: nxt_r.mask = r_ff.mask;
         endcase
      end
      if ((acc_w || acc_r) && window_open && (paddr == OFF_DATA_A)) begin
         nxt_r.acc[0] = 1'b1;
      end
      if ((acc_w || acc_r) && window_open && (paddr == OFF_DATA_B)) begin
         nxt_r.acc[1] = 1'b1;
      end
      // Only bits that were actually returned are cleared
      nxt_r.win_irq = r_ff.win_irq && !(rd_stat && r_ff.prdata[STAT_WIN_BIT]);
      nxt_r.ovf_irq = r_ff.ovf_irq && !(rd_stat && r_ff.prdata[STAT_OVF_BIT]);
      case (r_ff.st)
         ST_OPEN: begin
            nxt_r.open_len = r_ff.open_len + 16'h0001;
            if (close_ev) begin
               nxt_r.st = ST_WR;
               nxt_r.ch = !en[0];
               nxt_r.full = 1'b0;
               if ((en[0] && !r_ff.acc[0]) || (en[1] && !r_ff.acc[1])) begin
                  nxt_r.ovf_irq = 1'b1;
               end
            end
         end
         ST_WR: begin
            if (en[r_ff.ch]) begin
               nxt_r.wr_en = 1'b1;
               nxt_r.wr_cfi = r_ff.txa[r_ff.ch][IFACE_SEL_BIT];
               nxt_r.wr_addr = r_ff.txa[r_ff.ch][SLOT_W-1:0];
               nxt_r.wr_data = r_ff.data[r_ff.ch];
               nxt_r.wr_mask = sel_mask[r_ff.ch];
            end
            nxt_r.st = ST_RD;
         end
         ST_RD: begin
            if (en[r_ff.ch]) begin
               nxt_r.rd_en = 1'b1;
               nxt_r.rd_cfi = r_ff.rxa[r_ff.ch][IFACE_SEL_BIT];
               nxt_r.rd_addr = r_ff.rxa[r_ff.ch][SLOT_W-1:0];
            end
            nxt_r.st = ST_RWAIT;
         end
         ST_RWAIT: begin
            nxt_r.st = ST_CAP;
         end
         ST_CAP: begin
            if (en[r_ff.ch]) begin
               nxt_r.data[r_ff.ch] = merged[r_ff.ch];
            end
            if (!r_ff.ch && en[1]) begin
               nxt_r.ch = 1'b1;
               nxt_r.st = ST_WR;
            end else begin
               nxt_r.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            nxt_r.st = ST_WAIT;
         end
         default: begin
            nxt_r.st = ST_WAIT;
         end
      endcase
      // Dropping all channels disarms the window until the next wrap
      if (!any_en) begin
         nxt_r.full = 1'b0;
      end
      if (reopen) begin
         nxt_r.st = ST_OPEN;
         nxt_r.acc = 2'b00;
         nxt_r.open_len = '0;
         nxt_r.full = any_en;
         if (any_en) begin
            nxt_r.win_irq = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign prdata = r_ff.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign mem_rd_en = r_ff.rd_en;
   assign mem_rd_cfi = r_ff.rd_cfi;
   assign mem_rd_addr = r_ff.rd_addr;
   assign mem_wr_en = r_ff.wr_en;
   assign mem_wr_cfi = r_ff.wr_cfi;
   assign mem_wr_addr = r_ff.wr_addr;
   assign mem_wr_data = r_ff.wr_data;
   assign mem_wr_mask = r_ff.wr_mask;
   assign irq = |(stat_byte & ~r_ff.mask);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_close;
      close_ev;
   endsequence

   sequence s_tx_rx(logic c);
      (r_ff.st == ST_WR) ##1 (mem_wr_en && r_ff.ch == c) ##2 (r_ff.st == ST_CAP);
   endsequence

   sequence s_b_next;
      (r_ff.st == ST_WR) && r_ff.ch;
   endsequence

   win_flag_set_a: assert property ($rose(window_open) |-> r_ff.win_irq)
      else $error("window opened without window flag");

   win_needs_en_a: assert property ($rose(r_ff.win_irq) |-> $past(any_en))
      else $error("window flag set with no channel enabled");

   win_clear_a: assert property ((rd_stat && r_ff.prdata[STAT_WIN_BIT] && !reopen)
      |=> !r_ff.win_irq)
      else $error("window flag survived status read");

   ovf_clear_a: assert property ((rd_stat && r_ff.prdata[STAT_OVF_BIT] && !close_ev)
      |=> !r_ff.ovf_irq)
      else $error("overflow flag survived status read");

   window_len_a: assert property ((close_ev && r_ff.full && $stable(r_ff.ctrl))
      |-> (r_ff.open_len + closed_len + 16'h0001 == FRAME_LAST + 16'h0001))
      else $error("access window length wrong");

   overflow_set_a: assert property ((close_ev && en[0] && !r_ff.acc[0]) |=> r_ff.ovf_irq)
      else $error("missed access without overflow");

   loop_a_a: assert property ((s_close ##0 (en[0] && $stable(r_ff.ctrl))) |=> s_tx_rx(1'b0))
      else $error("channel A not looped after close");

   tx_target_a: assert property (mem_wr_en |->
      (mem_wr_cfi == r_ff.txa[r_ff.ch][IFACE_SEL_BIT]
      && mem_wr_addr == r_ff.txa[r_ff.ch][SLOT_W-1:0]
      && mem_wr_mask == type_mask(ctype[r_ff.ch])))
      else $error("transmit target or mask wrong");

   rx_source_a: assert property (mem_rd_en |->
      (mem_rd_cfi == r_ff.rxa[r_ff.ch][IFACE_SEL_BIT]
      && mem_rd_addr == r_ff.rxa[r_ff.ch][SLOT_W-1:0]) ##1 (r_ff.st == ST_CAP))
      else $error("receive source wrong");

   capture_keep_a: assert property ((r_ff.st == ST_CAP && en[r_ff.ch] && !r_ff.ch)
      |=> ((r_ff.data[0] & ~$past(sel_mask[0])) == ($past(r_ff.data[0]) & ~$past(sel_mask[0]))
      && (r_ff.data[0] & $past(sel_mask[0])) == ($past(mem_rd_data) & $past(sel_mask[0]))))
      else $error("capture touched unselected bits");

   loop_b_a: assert property ((s_close ##0 (en[1] && !en[0] && $stable(r_ff.ctrl)))
      |=> s_tx_rx(1'b1))
      else $error("channel B not looped after close");

   b_after_a_a: assert property ((r_ff.st == ST_CAP && !r_ff.ch && en[1]) |=> s_b_next)
      else $error("channel B did not follow channel A");

   ch_skip_a: assert property ((r_ff.st == ST_CAP && (r_ff.ch || !en[1]))
      |=> (r_ff.st == ST_WAIT))
      else $error("transfer did not end after last channel");

   tx_data_a: assert property (mem_wr_en
      |-> (mem_wr_data == $past(r_ff.data[r_ff.ch])))
      else $error("transmitted byte is not the data register");

   tx_off_a: assert property (mem_wr_en |-> $past(en[r_ff.ch]))
      else $error("disabled channel transmitted");

   rx_off_a: assert property (mem_rd_en |-> $past(en[r_ff.ch]))
      else $error("disabled channel received");

   wr_pulse_a: assert property (mem_wr_en |=> !mem_wr_en)
      else $error("transmit strobe longer than one cycle");

   win_idle_a: assert property ((reopen && !any_en) |=> !window_open)
      else $error("window opened with no channel enabled");

   irq_masked_a: assert property ((r_ff.mask[STAT_WIN_BIT] && r_ff.mask[STAT_OVF_BIT])
      |-> !irq)
      else $error("masked interrupt reached irq");

   close_pos_a: assert property (($fell(window_open) && $stable(r_ff.ctrl))
      |-> (r_ff.cnt == close_pos + 16'h0001))
      else $error("window closed off its frame position");

   open_pos_a: assert property ($rose(window_open) |-> (r_ff.cnt == 16'h0000))
      else $error("window opened off its frame position");

   ovf_none_a: assert property ((close_ev && !r_ff.ovf_irq
      && (!en[0] || r_ff.acc[0]) && (!en[1] || r_ff.acc[1])) |=> !r_ff.ovf_irq)
      else $error("overflow set although channels were accessed");

   win_sticky_a: assert property ((r_ff.win_irq && !rd_stat) |=> r_ff.win_irq)
      else $error("window flag lost without status read");

   ovf_sticky_a: assert property ((r_ff.ovf_irq && !rd_stat) |=> r_ff.ovf_irq)
      else $error("overflow flag lost without status read");

   data_hold_a: assert property ((!window_open
      && (r_ff.st == ST_WAIT || r_ff.st == ST_OPEN)) |=> $stable(r_ff.data))
      else $error("data register changed outside window and transfer");
endmodule
`default_nettype wire

/* tb/sts_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sts_mem_model (
   input wire logic pclk,
   input wire logic rd_en,
   input wire logic rd_cfi,
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic wr_en,
   input wire logic wr_cfi,
   input wire logic [6:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] wr_mask
);
   logic [7:0] pcm [128];
   logic [7:0] configurable_serial_iface [128];
   // Read data stands for one cycle only, then it toggles
   always @(posedge pclk) begin
      if (rd_en) begin
         rd_data <= rd_cfi ? configurable_serial_iface[rd_addr] : pcm[rd_addr];
      end else begin
         rd_data <= ~rd_data;
      end
      if (wr_en && wr_cfi) begin
         configurable_serial_iface[wr_addr] <= (configurable_serial_iface[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
      end
      if (wr_en && !wr_cfi) begin
         pcm[wr_addr] <= (pcm[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
      end
   end
endmodule
`default_nettype wire

/* tb/sts_xfer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sts_xfer_tb_top;
   import sts_pkg::*;
   localparam int FR = 200;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, window_open, irq, er;
   logic [7:0] paddr, rd_data, wr_data, wr_mask, src, m, exp_d, exp_t;
   logic [31:0] pwdata, prdata, rdw;
   logic rd_en, rd_cfi, wr_en, wr_cfi;
   logic [6:0] rd_addr, wr_addr;
   int fail_count, checks_done, n;
   sts_xfer #(.FRAME_CYCLES(FR)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mem_rd_en(rd_en), .mem_rd_cfi(rd_cfi),
      .mem_rd_addr(rd_addr), .mem_rd_data(rd_data), .mem_wr_en(wr_en), .mem_wr_cfi(wr_cfi),
      .mem_wr_addr(wr_addr), .mem_wr_data(wr_data), .mem_wr_mask(wr_mask),
      .window_open(window_open), .irq(irq));
   sts_mem_model mem (.pclk(pclk), .rd_en(rd_en), .rd_cfi(rd_cfi), .rd_addr(rd_addr),
      .rd_data(rd_data), .wr_en(wr_en), .wr_cfi(wr_cfi), .wr_addr(wr_addr),
      .wr_data(wr_data), .wr_mask(wr_mask));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask
   task automatic wait_win(input logic v);
      int k;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (window_open !== v && k < 3 * FR);
      chk({31'h0, window_open}, {31'h0, v});
   endtask
   task automatic win_len(input int exp);
      int c;
      wait_win(1'b1);
      wait_win(1'b0);
      c = 0;
      repeat (FR) begin
         @(negedge pclk);
         c += int'(window_open === 1'b1);
      end
      chk(32'(c), 32'(exp));
   endtask
   initial begin
      repeat (100 * FR) @(posedge pclk);
      fail_count++;
      final_report;
   end
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      fail_count = 0;
      checks_done = 0;
      exp_d = 8'h00;
      exp_t = 8'h3c;
      mem.pcm[7'h25] = 8'h3c;
      mem.configurable_serial_iface[7'h05] = 8'h5a;
      mem.configurable_serial_iface[7'h06] = 8'h00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (n = 0; n <= 32; n += 4) rdc(n[7:0], 32'h0);
      apb(1'b0, 8'h24, 32'h0, rdw, er);
      chk({31'h0, er}, 32'h1);
      chk(rdw, 32'h0);
      chk({31'h0, window_open}, 32'h0);
      $display("test reset done");
      wr(OFF_MASK, 8'h03);
      wr(OFF_RX_A, 8'h13);
      wr(OFF_TX_A, 8'h25);
      for (n = 0; n < 8; n++) begin
         m = n == 0 ? 8'h00 : n == 1 ? 8'hff :
             n < 4 ? 8'(8'h0f << 4 * (n - 2)) : 8'(8'h03 << 2 * (n - 4));
         src = 8'h96 ^ {n[3:0], n[3:0]};
         mem.pcm[7'h13] = src;
         wr(OFF_CTRL, 8'h40 | n[7:0]);
         repeat (3 * FR) @(posedge pclk);
         exp_d = (exp_d & ~m) | (src & m);
         exp_t = (exp_t & ~m) | (src & m);
         rdc(OFF_DATA_A, {24'h0, exp_d});
         chk({24'h0, mem.pcm[7'h25]}, {24'h0, exp_t});
         chk({31'h0, irq}, 32'h0);
      end
      wr(OFF_CTRL, 8'h00);
      rdc(OFF_STATUS, 32'h3);
      rdc(OFF_STATUS, 32'h0);
      $display("test pcm loop done");
      wr(OFF_MASK, 8'h00);
      wr(OFF_RX_B, 8'h85);
      wr(OFF_TX_B, 8'h86);
      wr(OFF_CTRL, 8'h88);
      win_len(FR - 17);
      wait_win(1'b1);
      apb(1'b0, OFF_STATUS, 32'h0, rdw, er);
      wr(OFF_DATA_B, 8'hc3);
      wait_win(1'b0);
      wait_win(1'b1);
      repeat (2) @(negedge pclk);
      chk({31'h0, irq}, 32'h1);
      rdc(OFF_STATUS, 32'h2);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      rdc(OFF_DATA_B, 32'h5a);
      chk({24'h0, mem.configurable_serial_iface[7'h06]}, 32'hc3);
      $display("test serial channel done");
      wr(OFF_CTRL, 8'hc9);
      win_len(FR - 33);
      $display("test both channels done");
      final_report;
   end
endmodule
`default_nettype wire
